// [hdl/hpip_pkg.sv]
// Package: constants, register map and carrier types of the parallel input port
package hpip_pkg;

  // Data path width
  localparam int DATA_W = 12;

  // Host address word layout: slot field in bits 15..12
  localparam int ADDR_W = 16;
  localparam int SLOT_LSB = 12;
  localparam int SLOT_W = 4;

  // Handshake flag minimum level time and clock rate
  localparam int FLAG_MIN_NS = 2000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int FLAG_MIN_CYC = (FLAG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // APB register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] HOST_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;

  // Configuration register bit positions
  localparam int CFG_POS_TRUE = 0;
  localparam int CFG_STORE = 1;
  localparam int CFG_REQ_HIGH = 2;
  localparam int CFG_FLAG_INV = 3;
  localparam int CFG_GROUP = 4;
  localparam int CFG_END_RET = 5;
  localparam int CFG_SLOT_LSB = 8;

  // Host control register bit positions
  localparam int HOST_ISL = 0;
  localparam int HOST_IEN = 1;
  localparam int HOST_STB = 2;
  localparam int HOST_ADDR_LSB = 16;

  // Reset values: negative-true, storage enabled, falling request, slot 0
  localparam logic [31:0] CFG_RST = 32'h0000_0002;
  localparam logic [31:0] HOST_RST = 32'h0000_0000;

  // Status register bit positions
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_REQ = 2;
  localparam int STAT_TFLAG = 3;
  localparam int STAT_IRQ = 4;
  localparam int STAT_FLAG = 5;

  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } hpip_apb_req_s;

  // APB answer carrier
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hpip_apb_rsp_s;

  // Flag edge events from the synchroniser
  typedef struct packed {
    logic level;
    logic busy_evt;
    logic ready_evt;
  } hpip_flag_s;

endpackage

// [hdl/hpip_flag_sync.sv]
// Two-stage synchroniser and edge detector for the handshake flag
`timescale 1ns/1ps
module hpip_flag_sync (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Raw flag pin and sense
  input wire logic flag_pin_i,
  input wire logic flag_inv_i,
  // Events
  output hpip_pkg::hpip_flag_s flag_o
);

  logic meta_reg; // First stage, read only by the second
  logic sync_reg; // Second stage
  logic last_reg; // Previous synchronised level
  logic busy_lvl; // Flag in busy sense

  // Sync chain
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= flag_pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Idle level is high by default, low when inverted; busy is the non-idle level
  assign busy_lvl = sync_reg ^ ~flag_inv_i;

  // One event per transition
  always_comb begin
    flag_o.level = busy_lvl;
    flag_o.busy_evt = (sync_reg != last_reg) && busy_lvl;
    flag_o.ready_evt = (sync_reg != last_reg) && !busy_lvl;
  end

endmodule

// [hdl/hpip_top.sv]
// Parallel input port with request/flag handshake and APB register access
//
// Behaviour
// - Twelve data inputs form one word
// - Negative-true: low input reads one
// - Positive-true: high input reads one
// - Request strobe falls by default, invertible
// - Storage captures data on ready edge
// - Storage disabled: data passes straight through
// - Slot decoded from address bits 15..12
// - Addressed in input-select returns stored word
// - Addressed strobe in interrupt-enable requests data
// - Group option requests on interrupt-enable entry
// - Timing flag: addressed-ready or enabled-active-ready
// - Input request: addressed, active and ready
// - Addressed strobe in input-select activates
// - Addressed strobe outside input-select deactivates
// - Inactive suppresses enabled timing flag, request
// - Request may loop back to flag
// - Request returns idle on busy, optionally ready
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module hpip_top #(
  parameter int DATA_W = hpip_pkg::DATA_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  // External device pins
  input wire logic [DATA_W-1:0] data_pin_i,
  input wire logic flag_pin_i,
  output logic gate_pin_o,
  // Host frame outputs
  output logic timing_flag_o,
  output logic input_request_o,
  output logic [DATA_W-1:0] host_data_o,
  output logic host_data_valid_o
);

  // Bus carriers
  hpip_pkg::hpip_apb_req_s req; // Gathered request
  hpip_pkg::hpip_flag_s flag; // Flag events

  // Registers
  logic [31:0] cfg_reg; // Configuration
  logic [31:0] host_reg; // Host frame control
  logic [DATA_W-1:0] d_meta_reg; // Data sync stage one
  logic [DATA_W-1:0] d_sync_reg; // Data sync stage two
  logic [DATA_W-1:0] store_reg; // Storage register
  logic active_reg; // Activation state
  logic ready_reg; // Data ready state
  logic req_reg; // Request outstanding, logical
  logic ien_last_reg; // Previous interrupt-enable mode
  logic gate_reg; // Gate pin driver
  logic tflag_reg; // Timing flag driver
  logic irq_reg; // Input request driver
  logic [DATA_W-1:0] hdata_reg; // Host data driver
  logic hvalid_reg; // Host data valid driver
  logic [31:0] rdata_reg; // Read data holder
  logic slverr_reg; // Error answer holder

  // Decoded conditions
  logic wr_acc; // Write access phase
  logic rd_acc; // Read setup phase
  logic addressed; // Slot matches
  logic stb; // Host strobe pulse written
  logic input_select_mode; // Input-select mode
  logic interrupt_enable_mode; // Interrupt-enable mode
  logic [DATA_W-1:0] data_logic; // Data in logical sense
  logic [DATA_W-1:0] word; // Word presented to host
  logic end_ret; // Return request only on ready
  logic stb_hit; // Strobe whose own address word names this slot
  logic stb_isl; // Input-select mode carried by the strobing write
  logic stb_ien; // Interrupt-enable mode carried by the strobing write

  // Register offset decode, used for the APB error answer of reads and writes
  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == hpip_pkg::CFG_OFS) || (a == hpip_pkg::HOST_OFS) ||
                (a == hpip_pkg::DATA_OFS) || (a == hpip_pkg::STAT_OFS);
  endfunction

  // Slot field of a host control word, for the held word and for a word being written
  function automatic logic [hpip_pkg::SLOT_W-1:0] slot_of(input logic [31:0] h);
    slot_of = h[hpip_pkg::HOST_ADDR_LSB + hpip_pkg::SLOT_LSB +: hpip_pkg::SLOT_W];
  endfunction

  // Gather APB request
  always_comb begin
    req.psel = psel_i;
    req.penable = penable_i;
    req.pwrite = pwrite_i;
    req.paddr = paddr_i;
    req.pwdata = pwdata_i;
  end

  assign wr_acc = req.psel && req.penable && req.pwrite;
  assign rd_acc = req.psel && !req.penable && !req.pwrite;

  // Mode and address decode
  assign input_select_mode = host_reg[hpip_pkg::HOST_ISL];
  assign interrupt_enable_mode = host_reg[hpip_pkg::HOST_IEN];
  assign end_ret = cfg_reg[hpip_pkg::CFG_END_RET];
  assign addressed = slot_of(host_reg)
                     == cfg_reg[hpip_pkg::CFG_SLOT_LSB +: hpip_pkg::SLOT_W];
  assign stb = wr_acc && (req.paddr == hpip_pkg::HOST_OFS) && req.pwdata[hpip_pkg::HOST_STB];

  // A strobe acts on the slot and modes of its own write; the held word is still stale then
  assign stb_hit = stb && (slot_of(req.pwdata)
                   == cfg_reg[hpip_pkg::CFG_SLOT_LSB +: hpip_pkg::SLOT_W]);
  assign stb_isl = req.pwdata[hpip_pkg::HOST_ISL];
  assign stb_ien = req.pwdata[hpip_pkg::HOST_IEN];

  // Flag synchroniser
  hpip_flag_sync u_flag_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .flag_pin_i(flag_pin_i),
    .flag_inv_i(cfg_reg[hpip_pkg::CFG_FLAG_INV]),
    .flag_o(flag)
  );

  // Data pin synchroniser
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      d_meta_reg <= '0;
      d_sync_reg <= '0;
    end else begin
      d_meta_reg <= data_pin_i;
      d_sync_reg <= d_meta_reg;
    end
  end

  // Sense conversion: negative-true unless positive-true selected
  assign data_logic = cfg_reg[hpip_pkg::CFG_POS_TRUE] ? d_sync_reg : ~d_sync_reg;

  // Word seen by host: stored or transparent
  assign word = cfg_reg[hpip_pkg::CFG_STORE] ? store_reg : data_logic;

  // Configuration register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_reg <= hpip_pkg::CFG_RST;
    end else if (wr_acc && req.paddr == hpip_pkg::CFG_OFS) begin
      cfg_reg <= req.pwdata;
    end
  end

  // Host control register; strobe bit self-clears
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      host_reg <= hpip_pkg::HOST_RST;
    end else if (wr_acc && req.paddr == hpip_pkg::HOST_OFS) begin
      host_reg <= req.pwdata & ~(32'h1 << hpip_pkg::HOST_STB);
    end
  end

  // Interrupt-enable entry tracking
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ien_last_reg <= 1'b0;
    end else begin
      ien_last_reg <= interrupt_enable_mode;
    end
  end

  // Storage register: capture on the ready edge
  // Data and flag share the same two-stage delay, so the word matches the pins at the edge
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      store_reg <= '0;
    end else if (flag.ready_evt) begin
      store_reg <= data_logic;
    end
  end

  // Data ready state: set on ready edge, cleared by the busy edge only
  // Busy and ready events never fall in one cycle, so no priority is needed here
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ready_reg <= 1'b0;
    end else if (flag.ready_evt) begin
      ready_reg <= 1'b1;
    end else if (flag.busy_evt) begin
      ready_reg <= 1'b0;
    end
  end

  // Activation state
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      active_reg <= 1'b0;
    end else if (stb_hit && stb_isl) begin
      // Addressed strobe in input-select mode
      active_reg <= 1'b1;
    end else if (stb_hit && !stb_isl) begin
      // Addressed strobe with input-select off
      active_reg <= 1'b0;
    end
  end

  // Request state: new request wins; return on busy or, optionally, on ready
  // A strobe while a request is outstanding is dropped, so the device never sees
  // two requests before it has answered the first
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      req_reg <= 1'b0;
    end else if (((stb_hit && (stb_ien || stb_isl)) ||
                  (cfg_reg[hpip_pkg::CFG_GROUP] && interrupt_enable_mode && !ien_last_reg)) && !req_reg) begin
      req_reg <= 1'b1;
    end else if (end_ret ? flag.ready_evt : flag.busy_evt) begin
      req_reg <= 1'b0;
    end
  end

  // Gate pin: idle high, low when requesting unless sense inverted
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      gate_reg <= 1'b1;
    end else begin
      gate_reg <= req_reg ^ ~cfg_reg[hpip_pkg::CFG_REQ_HIGH];
    end
  end

  // Timing flag: addressed with data, or enabled and active with data
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tflag_reg <= 1'b0;
    end else begin
      tflag_reg <= ready_reg && (addressed || (interrupt_enable_mode && active_reg));
    end
  end

  // Input request: only while addressed, active and holding data
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ready_reg && addressed && active_reg;
    end
  end

  // Host data: returned only when addressed in input-select
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hdata_reg <= '0;
      hvalid_reg <= 1'b0;
    end else if (addressed && input_select_mode) begin
      hdata_reg <= word;
      hvalid_reg <= 1'b1;
    end else begin
      hdata_reg <= '0;
      hvalid_reg <= 1'b0;
    end
  end

  // APB read data, captured in the setup cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_reg <= '0;
    end else if (rd_acc) begin
      case (req.paddr)
        hpip_pkg::CFG_OFS: rdata_reg <= cfg_reg;
        hpip_pkg::HOST_OFS: rdata_reg <= host_reg;
        hpip_pkg::DATA_OFS: rdata_reg <= {{(32 - DATA_W){1'b0}}, word};
        hpip_pkg::STAT_OFS: rdata_reg <= {26'h0, flag.level, irq_reg, tflag_reg,
                                         req_reg, ready_reg, active_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  // APB error for unmapped offsets
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      slverr_reg <= 1'b0;
    end else if (req.psel && !req.penable) begin
      slverr_reg <= !known_ofs(req.paddr);
    end
  end

  // Outputs
  assign pready_o = 1'b1;
  assign pslverr_o = req.psel && req.penable && slverr_reg;
  assign prdata_o = rdata_reg;
  assign gate_pin_o = gate_reg;
  assign timing_flag_o = tflag_reg;
  assign input_request_o = irq_reg;
  assign host_data_o = hdata_reg;
  assign host_data_valid_o = hvalid_reg;

endmodule

// [tb/hpip_props.sv]
// Checker for the request strobe, flag handshake and host outputs
`timescale 1ns/1ps
module hpip_props #(
  parameter int DATA_W = hpip_pkg::DATA_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // APB request
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  // Pins and host outputs
  input wire logic flag_pin_i,
  input wire logic gate_pin_o,
  input wire logic timing_flag_o,
  input wire logic input_request_o,
  input wire logic [DATA_W-1:0] host_data_o,
  input wire logic host_data_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Shadow of the configuration word
  logic [31:0] cfg_q;
  // Host write carrying a strobe
  logic hstb;
  assign hstb = psel_i && penable_i && pwrite_i && paddr_i == hpip_pkg::HOST_OFS
    && pwdata_i[hpip_pkg::HOST_STB];
  // Track configuration writes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_q <= hpip_pkg::CFG_RST;
    end else if (psel_i && penable_i && pwrite_i && paddr_i == hpip_pkg::CFG_OFS) begin
      cfg_q <= pwdata_i;
    end
  end
  rst_idle_a: assert property ($fell(srst_i) |-> gate_pin_o && !input_request_o)
    else $error("gate not idle after reset");
  gate_cause_a: assert property ($fell(gate_pin_o) && cfg_q[4:2] == 3'h0 |->
    $past(hstb) || $past(hstb, 2) || $past(hstb, 3)) else $error("request without strobe");
  gate_hold_a: assert property ($fell(gate_pin_o) && !cfg_q[2] |=> !gate_pin_o [*6])
    else $error("request dropped early");
  busy_ret_a: assert property ($fell(flag_pin_i) && !gate_pin_o && cfg_q[5:2] == 4'h0
    |-> ##[1:6] gate_pin_o) else $error("request not returned on busy");
  ready_ret_a: assert property ($fell(flag_pin_i) && !gate_pin_o && cfg_q[5]
    && cfg_q[3:2] == 2'h0 |=> !gate_pin_o [*8]) else $error("request returned on busy");
  irq_tf_a: assert property (input_request_o |-> timing_flag_o)
    else $error("input request without timing flag");
  hdata_zero_a: assert property (!host_data_valid_o |-> host_data_o == '0)
    else $error("host data without valid");
  tf_ready_a: assert property ($rose(timing_flag_o) && !cfg_q[3] |-> flag_pin_i)
    else $error("timing flag while busy");
  irq_off_a: assert property (hstb && !pwdata_i[hpip_pkg::HOST_ISL]
    && pwdata_i[31:28] == cfg_q[11:8] |-> ##[1:3] !input_request_o)
    else $error("input request after deactivation");
  // Main scenarios
  cover property ($fell(gate_pin_o));
  cover property ($rose(input_request_o));
  cover property (hstb && !pwdata_i[hpip_pkg::HOST_ISL]);
endmodule

bind hpip_top hpip_props #(.DATA_W(DATA_W)) props_u (.core_clk_i, .srst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .flag_pin_i, .gate_pin_o, .timing_flag_o,
  .input_request_o, .host_data_o, .host_data_valid_o);

// [tb/hpip_dev_model.sv]
// Behavioural external data source with busy/ready flag
`timescale 1ns/1ps
module hpip_dev_model (
  // Clock and request strobe
  input wire logic core_clk_i,
  input wire logic gate_pin_i,
  // Word to present
  input wire logic [11:0] word_i,
  // Flag and data pins
  output logic flag_pin_o,
  output logic [11:0] data_pin_o
);
  // Answer each request: busy, present word, ready, hold, then spoil data
  initial begin
    flag_pin_o = 1'b1;
    data_pin_o = 12'hFFF;
    forever begin
      @(negedge gate_pin_i);
      repeat (6) @(posedge core_clk_i);
      flag_pin_o <= 1'b0;
      repeat (12) @(posedge core_clk_i);
      data_pin_o <= word_i;
      repeat (13) @(posedge core_clk_i);
      flag_pin_o <= 1'b1;
      repeat (30) @(posedge core_clk_i);
      data_pin_o <= ~word_i;
    end
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the parallel input port
`timescale 1ns/1ps
module testbench;
  // Clock, reset and APB drive
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  // Design outputs and device pins
  logic pready_o, pslverr_o, gate_pin_o, timing_flag_o, input_request_o, host_data_valid_o;
  logic [31:0] prdata_o, rd;
  logic [11:0] data_pin_i, host_data_o, xw;
  logic [11:0] word_q = 12'h000;
  logic flag_pin_i, err;
  // Host frame view: one port here, so the combined flag is this port's flag
  logic combined_timing_flag;
  logic [15:0] frame_word;
  assign combined_timing_flag = |{timing_flag_o, 1'b0};
  assign frame_word = {input_request_o, 3'h0, host_data_o};
  int n_mismatch = 0;
  int cmp_count = 0;
  // Configurations and words for the handshake runs
  logic [31:0] cfgs [3] = '{32'h0000_0302, 32'h0000_0303, 32'h0000_0322};
  logic [11:0] words [3] = '{12'hA5C, 12'h3C1, 12'h0F0};
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  hpip_top dut_u (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .pslverr_o, .prdata_o, .data_pin_i, .flag_pin_i, .gate_pin_o, .timing_flag_o,
    .input_request_o, .host_data_o, .host_data_valid_o);
  hpip_dev_model dev_u (.core_clk_i, .gate_pin_i(gate_pin_o), .word_i(word_q),
    .flag_pin_o(flag_pin_i), .data_pin_o(data_pin_i));
  // Verdict and end of run
  task automatic final_report;
    $display("Mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // One APB transfer, waiting for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge keeps two calls from assigning psel in one time step
    @(posedge core_clk_i);
    if (i == 20) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // Wait for the timing flag to reach a level
  task automatic wait_tf(input logic v);
    int i;
    for (i = 0; i < 300 && combined_timing_flag !== v; i++) @(posedge core_clk_i);
    if (i == 300) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // Flags packed as {timing, request}
  task automatic chk_flags(input logic [1:0] want);
    chk({30'h0, timing_flag_o, input_request_o}, {30'h0, want});
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    apb(1'b0, hpip_pkg::CFG_OFS, 32'h0);
    chk(rd, hpip_pkg::CFG_RST);
    apb(1'b0, hpip_pkg::HOST_OFS, 32'h0);
    chk(rd, hpip_pkg::HOST_RST);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h0000_0001);
    // Full handshakes in each data sense and return option
    foreach (cfgs[k]) begin
      word_q <= words[k];
      apb(1'b1, hpip_pkg::CFG_OFS, cfgs[k]);
      apb(1'b1, hpip_pkg::HOST_OFS, 32'h3ABC_0005);
      wait_tf(1'b0);
      wait_tf(1'b1);
      xw = cfgs[k][0] ? words[k] : ~words[k];
      chk({20'h0, host_data_o}, {20'h0, xw});
      chk_flags(2'b11);
      chk({16'h0, frame_word}, {16'h0, 1'b1, 3'h0, xw});
      repeat (40) @(posedge core_clk_i);
      apb(1'b0, hpip_pkg::DATA_OFS, 32'h0);
      chk(rd, {20'h0, xw});
    end
    apb(1'b1, hpip_pkg::HOST_OFS, 32'h0FFF_0002);
    repeat (3) @(posedge core_clk_i);
    chk_flags(2'b10);
    apb(1'b1, hpip_pkg::HOST_OFS, 32'h3000_0004);
    repeat (3) @(posedge core_clk_i);
    chk_flags(2'b10);
    apb(1'b1, hpip_pkg::HOST_OFS, 32'h0000_0002);
    repeat (3) @(posedge core_clk_i);
    chk_flags(2'b00);
    // Group option: entering interrupt-enable mode requests without a strobe
    word_q <= 12'h5A3;
    apb(1'b1, hpip_pkg::CFG_OFS, 32'h0000_0312);
    apb(1'b1, hpip_pkg::HOST_OFS, 32'h0000_0000);
    apb(1'b1, hpip_pkg::HOST_OFS, 32'h0000_0002);
    repeat (80) @(posedge core_clk_i);
    apb(1'b0, hpip_pkg::DATA_OFS, 32'h0);
    chk(rd, {20'h0, ~12'h5A3});
    // Addressed strobe in interrupt-enable mode requests and deactivates
    word_q <= 12'h1E7;
    apb(1'b1, hpip_pkg::CFG_OFS, 32'h0000_0302);
    apb(1'b1, hpip_pkg::HOST_OFS, 32'h3000_0006);
    repeat (60) @(posedge core_clk_i);
    chk_flags(2'b10);
    apb(1'b0, hpip_pkg::DATA_OFS, 32'h0);
    chk(rd, {20'h0, ~12'h1E7});
    // Storage off: pins pass straight through
    apb(1'b1, hpip_pkg::CFG_OFS, 32'h0000_0300);
    apb(1'b1, hpip_pkg::HOST_OFS, 32'h3000_0001);
    repeat (4) @(posedge core_clk_i);
    apb(1'b0, hpip_pkg::DATA_OFS, 32'h0);
    chk(rd, {20'h0, ~data_pin_i});
    final_report();
  end
endmodule
